// >>> dv/eid_cpu_model.sv
// cpu side model that takes pending requests on command
`timescale 1ns/10ps
module eid_cpu_model
	import eid_pkg::*;
#(
	parameter int LAT = 3
)
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       ack_en,
	input  wire logic [5:0] irq_req,
	input  wire logic       nmi_req,
	output logic      [5:0] exc_taken,
	output logic            nmi_taken
);
	int wait_cnt;

	// ==========================================================
	// take one exception, then stay busy for LAT cycles
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			exc_taken <= 6'h00;
			nmi_taken <= 1'b0;
			wait_cnt  <= 0;
		end
		else
		begin
			exc_taken <= 6'h00;
			nmi_taken <= 1'b0;
			if (wait_cnt != 0)
				wait_cnt <= wait_cnt - 1;
			else if (ack_en && nmi_req)
			begin
				nmi_taken <= 1'b1;
				wait_cnt  <= LAT;
			end
			else if (ack_en && irq_req != 6'h00)
			begin
				exc_taken <= irq_req & (~irq_req + 6'h01);
				wait_cnt  <= LAT;
			end
		end
	end
endmodule : eid_cpu_model

// >>> dv/external_irq_detect_status_tb_top.sv
// self-checking testbench for the external request detector
`timescale 1ns/10ps
`include "eid_defines.svh"
module external_irq_detect_status_tb_top
	import eid_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        nmi_pin, nmi_taken, nmi_req, wake_req, ack_en, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb, int_src_flag;
	logic [5:0]  ext_req_n, exc_taken, irq_req;
	eid_req_t    best_req;
	int          n_mismatch, checked, cycles;

	eid_detect DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_req_n(ext_req_n), .nmi_pin(nmi_pin), .exc_taken(exc_taken),
		.nmi_taken(nmi_taken), .int_src_flag(int_src_flag), .nmi_req(nmi_req), .irq_req(irq_req),
		.best_req(best_req), .wake_req(wake_req));
	eid_cpu_model #(.LAT(3)) cpu (.pclk(pclk), .presetn(presetn), .ack_en(ack_en), .irq_req(irq_req),
		.nmi_req(nmi_req), .exc_taken(exc_taken), .nmi_taken(nmi_taken));

	// ==========================================================
	// clock, timeout and shared tasks
	always #2 pclk = ~pclk;

	always @(posedge pclk)
	begin
		cycles = cycles + 1;
		if (cycles == 4000)
		begin
			n_mismatch++;
			conclude();
		end
	end

	task conclude();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude

	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(a, 1'b0, 32'h0);
		chk(nm, e, rd);
	endtask : rdchk

	// ==========================================================
	// scenarios
	task t_reset();
		rdchk(`EID_OFF_SENSE_LOW, 32'h0, "sense_low");
		rdchk(`EID_OFF_STATUS, 32'h0, "status");
		rdchk(`EID_OFF_ENABLE, 32'h0, "enable");
		rdchk(`EID_OFF_PRIO_A, 32'h77, "prio_a");
	endtask : t_reset

	task t_regs();
		apb(`EID_OFF_SENSE_LOW, 1'b1, 32'h39);
		rdchk(`EID_OFF_SENSE_LOW, 32'h39, "sense_fields");
		pstrb <= 4'h0;
		apb(`EID_OFF_SENSE_LOW, 1'b1, 32'h3F);
		pstrb <= 4'hF;
		rdchk(`EID_OFF_SENSE_LOW, 32'h39, "strobe_off");
		apb(12'h030, 1'b0, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, er});
		apb(`EID_OFF_SENSE_LOW, 1'b1, 32'h01);
	endtask : t_regs

	task t_internal();
		int_src_flag <= 4'h1;
		apb(`EID_OFF_INT_ENABLE, 1'b1, 32'h0);
		repeat (3) @(posedge pclk);
		chk("int_masked", 32'h0, {31'h0, best_req.valid});
		apb(`EID_OFF_INT_ENABLE, 1'b1, 32'h1);
		repeat (3) @(posedge pclk);
		chk("int_req", 32'hF6, {24'h0, best_req});
		int_src_flag <= 4'h0;
		apb(`EID_OFF_INT_ENABLE, 1'b1, 32'h0);
	endtask : t_internal

	task t_clear();
		ext_req_n[0] <= 1'b0;
		repeat (6) @(posedge pclk);
		chk("irq_masked", 32'h0, {26'h0, irq_req});
		apb(`EID_OFF_STATUS, 1'b1, 32'h0);
		rdchk(`EID_OFF_STATUS, 32'h1, "status_held");
		apb(`EID_OFF_ENABLE, 1'b1, 32'h1);
		apb(`EID_OFF_PRIO_A, 1'b1, 32'h30);
		repeat (2) @(posedge pclk);
		chk("irq_on", 32'h1, {26'h0, irq_req});
		chk("best_level", 32'h3, {29'h0, best_req.level});
		apb(`EID_OFF_STATUS, 1'b1, 32'h0);
		rdchk(`EID_OFF_STATUS, 32'h0, "status_cleared");
	endtask : t_clear

	task t_cpu();
		apb(`EID_OFF_ENABLE, 1'b1, 32'h3);
		ext_req_n[0] <= 1'b1;
		repeat (6) @(posedge pclk);
		ext_req_n[0] <= 1'b0;
		repeat (6) @(posedge pclk);
		rdchk(`EID_OFF_STATUS, 32'h1, "fall_seen");
		ack_en <= 1'b1;
		repeat (10) @(posedge pclk);
		rdchk(`EID_OFF_STATUS, 32'h0, "edge_taken");
		ext_req_n[1] <= 1'b0;
		repeat (10) @(posedge pclk);
		rdchk(`EID_OFF_STATUS, 32'h2, "level_low_kept");
		ext_req_n[1] <= 1'b1;
		repeat (10) @(posedge pclk);
		rdchk(`EID_OFF_STATUS, 32'h0, "level_high_taken");
		ack_en <= 1'b0;
	endtask : t_cpu

	task t_edges();
		apb(`EID_OFF_SENSE_LOW, 1'b1, 32'h21);
		apb(`EID_OFF_SENSE_HIGH, 1'b1, 32'h03);
		rdchk(`EID_OFF_SENSE_HIGH, 32'h03, "sense_high");
		ext_req_n[3:2] <= 2'h0;
		repeat (6) @(posedge pclk);
		rdchk(`EID_OFF_STATUS, 32'h8, "fall_modes");
		apb(`EID_OFF_STATUS, 1'b1, 32'h0);
		ext_req_n[3:2] <= 2'h3;
		repeat (6) @(posedge pclk);
		rdchk(`EID_OFF_STATUS, 32'hC, "rise_modes");
		apb(`EID_OFF_STATUS, 1'b1, 32'h0);
		rdchk(`EID_OFF_STATUS, 32'h0, "edges_cleared");
	endtask : t_edges

	task t_nmi();
		apb(`EID_OFF_SYSCTL, 1'b1, 32'h0);
		nmi_pin <= 1'b0;
		repeat (6) @(posedge pclk);
		chk("nmi_fall", 32'h1, {31'h0, nmi_req});
		chk("wake", 32'h1, {31'h0, wake_req});
		ack_en <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("nmi_taken", 32'h0, {31'h0, nmi_req});
		ack_en <= 1'b0;
		apb(`EID_OFF_SYSCTL, 1'b1, 32'h08);
		nmi_pin <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("nmi_rise", 32'h1, {31'h0, nmi_req});
	endtask : t_nmi

	// ==========================================================
	// main sequence
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		ext_req_n = 6'h3F;
		nmi_pin = 1'b1;
		int_src_flag = 4'h0;
		ack_en = 1'b0;
		n_mismatch = 0;
		checked = 0;
		cycles = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_regs();
		t_internal();
		t_clear();
		t_cpu();
		t_edges();
		t_nmi();
		conclude();
	end
endmodule : external_irq_detect_status_tb_top

// >>> rtl/eid_defines.svh
// register offsets, field positions, reset values and input counts for the external request detector
`ifndef EID_DEFINES_SVH
`define EID_DEFINES_SVH

`define EID_OFF_SENSE_LOW   12'h000
`define EID_OFF_SENSE_HIGH  12'h004
`define EID_OFF_STATUS      12'h008
`define EID_OFF_ENABLE      12'h00C
`define EID_OFF_PRIO_A      12'h010
`define EID_OFF_PRIO_B      12'h014
`define EID_OFF_PRIO_INT    12'h018
`define EID_OFF_SYSCTL      12'h01C
`define EID_OFF_INT_FLAG    12'h020
`define EID_OFF_INT_ENABLE  12'h024

`define EID_NUM_IN          6
`define EID_NUM_INT         4
`define EID_SENSE_RST       12'h000
`define EID_STATUS_RST      6'h00
`define EID_ENABLE_RST      6'h00
`define EID_PRIO_RST        3'h7
`define EID_NMI_EDGE_BIT    3
`define EID_STATUS_BITS     6

`endif

// >>> rtl/eid_detect.sv
// external request detection, pending status, enables, priorities and internal request gating
//
// Behaviour
// - two-bit sense code per input: low level, falling, rising, both edges.
// - low sense register holds input 2 at 5:4, 1 at 3:2, 0 at 1:0.
// - sense codes reset to zero and are read/write.
// - pending flag sets when the selected sense condition occurs.
// - software clears pending only by reading it as 1, then writing 0.
// - low-level mode: taken exception clears pending while the pin is high.
// - edge modes: taken exception clears pending at any pin level, unless a new edge hits in the same cycle.
// - six external requests, each able to wake from standby.
// - non-maskable request always accepted with top priority.
// - edge select bit picks rising or falling non-maskable edge.
// - maskable request reaches the CPU only when its enable bit is set.
// - maskable request carries its programmed priority level.
// - detection is independent of pin direction.
// - internal request issued only when flag and enable are both 1.
// - status flags clearable by software; internal sources take priority levels too.
// - enable bit n enables input n; all reset to 0.
// - priority fields are three bits, 000 lowest, 111 highest.
// - equal levels resolve to the lower source number; fixed order.
`timescale 1ns/10ps
`include "eid_defines.svh"
module eid_detect
	import eid_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [5:0]  ext_req_n,
	input  wire logic        nmi_pin,
	input  wire logic [5:0]  exc_taken,
	input  wire logic        nmi_taken,
	input  wire logic [3:0]  int_src_flag,
	output logic             nmi_req,
	output logic      [5:0]  irq_req,
	output eid_req_t         best_req,
	output logic             wake_req
);
	// ==========================================================
	// functions
	function automatic logic sense_hit(input logic [1:0] code, input logic lvl, input logic fl, input logic rs);
		case (eid_sense_t'(code))
			EID_SENSE_LOW:  sense_hit = ~lvl;
			EID_SENSE_FALL: sense_hit = fl;
			EID_SENSE_RISE: sense_hit = rs;
			EID_SENSE_BOTH: sense_hit = fl | rs;
			default:        sense_hit = 1'b0;
		endcase
	endfunction : sense_hit

	function automatic logic [2:0] prio_field(input logic [7:0] r, input logic hi);
		prio_field = hi ? r[6:4] : r[2:0];
	endfunction : prio_field

	// ==========================================================
	// pin synchronisers
	logic [5:0] pin_lvl;
	logic [5:0] pin_fall;
	logic [5:0] pin_rise;
	logic       nmi_lvl;
	logic       nmi_fall;
	logic       nmi_rise;

	// pins are sampled regardless of their direction setting
	genvar gi;
	generate
		for (gi = 0; gi < `EID_NUM_IN; gi++)
		begin : g_sync
			eid_sync u_sync
			(
				.pclk    (pclk),
				.presetn (presetn),
				.pin     (ext_req_n[gi]),
				.level   (pin_lvl[gi]),
				.fall    (pin_fall[gi]),
				.rise    (pin_rise[gi])
			);
		end
	endgenerate

	eid_sync u_nmi_sync
	(
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (nmi_pin),
		.level   (nmi_lvl),
		.fall    (nmi_fall),
		.rise    (nmi_rise)
	);

	// ==========================================================
	// registers
	logic [11:0]    sense;
	logic [5:0]     pending;
	logic [5:0]     read_one;
	logic [5:0]     enable;
	logic [7:0]     prio_a;
	logic [7:0]     prio_b;
	logic [7:0]     prio_int;
	logic           nmi_edge;
	logic [3:0]     int_enable;
	eid_clr_state_t clr_state;
	logic [11:0]    next_sense;
	logic [5:0]     next_pending;
	logic [5:0]     next_read_one;
	logic [5:0]     next_enable;
	logic [7:0]     next_prio_a;
	logic [7:0]     next_prio_b;
	logic [7:0]     next_prio_int;
	logic           next_nmi_edge;
	logic [3:0]     next_int_enable;
	eid_clr_state_t next_clr_state;

	logic       wr;
	logic       rd;
	logic [5:0] hit;
	logic [5:0] exc_clr;
	logic [5:0] sw_clr;

	assign wr = psel & penable & pwrite & pready;
	assign rd = psel & penable & ~pwrite & pready;

	always_comb
	begin
		next_sense      = sense;
		next_enable     = enable;
		next_prio_a     = prio_a;
		next_prio_b     = prio_b;
		next_prio_int   = prio_int;
		next_nmi_edge   = nmi_edge;
		next_int_enable = int_enable;
		next_read_one   = read_one;
		next_clr_state  = clr_state;
		sw_clr          = 6'h00;
		for (int i = 0; i < `EID_NUM_IN; i++)
		begin
			hit[i]     = sense_hit(sense[2*i +: 2], pin_lvl[i], pin_fall[i], pin_rise[i]);
			// level mode only clears when the pin has returned high
			exc_clr[i] = exc_taken[i] &
				((sense[2*i +: 2] == 2'h0) ? pin_lvl[i] : 1'b1);
		end
		if (rd && paddr == `EID_OFF_STATUS)
		begin
			// arm only flags that the returned word showed as one
			next_read_one  = read_one | (pending & prdata[5:0]);
			next_clr_state = EID_CLR_ARMED;
		end
		if (wr && pstrb[0])
		begin
			case (paddr)
				`EID_OFF_SENSE_LOW:  next_sense[5:0] = pwdata[5:0];
				`EID_OFF_SENSE_HIGH: next_sense[11:6] = pwdata[5:0];
				`EID_OFF_STATUS:
				begin
					// a zero only clears a flag previously read as one
					sw_clr         = (clr_state == EID_CLR_ARMED) ? (read_one & ~pwdata[5:0]) : 6'h00;
					next_read_one  = read_one & ~sw_clr;
					next_clr_state = (next_read_one == 6'h00) ? EID_CLR_IDLE : EID_CLR_ARMED;
				end
				`EID_OFF_ENABLE:     next_enable = pwdata[5:0];
				`EID_OFF_PRIO_A:     next_prio_a = {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
				`EID_OFF_PRIO_B:     next_prio_b = {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
				`EID_OFF_PRIO_INT:   next_prio_int = {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
				`EID_OFF_SYSCTL:     next_nmi_edge = pwdata[`EID_NMI_EDGE_BIT];
				`EID_OFF_INT_ENABLE: next_int_enable = pwdata[3:0];
				default:             next_nmi_edge = nmi_edge;
			endcase
		end
		// new events win over any clear in the same cycle
		next_pending  = (pending & ~sw_clr & ~exc_clr) | hit;
		next_read_one = next_read_one & next_pending;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sense      <= `EID_SENSE_RST;
			pending    <= `EID_STATUS_RST;
			read_one   <= 6'h00;
			enable     <= `EID_ENABLE_RST;
			prio_a     <= {1'b0, `EID_PRIO_RST, 1'b0, `EID_PRIO_RST};
			prio_b     <= {1'b0, `EID_PRIO_RST, 1'b0, `EID_PRIO_RST};
			prio_int   <= {1'b0, `EID_PRIO_RST, 1'b0, `EID_PRIO_RST};
			nmi_edge   <= 1'b0;
			int_enable <= 4'h0;
			clr_state  <= EID_CLR_IDLE;
		end
		else
		begin
			sense      <= next_sense;
			pending    <= next_pending;
			read_one   <= next_read_one;
			enable     <= next_enable;
			prio_a     <= next_prio_a;
			prio_b     <= next_prio_b;
			prio_int   <= next_prio_int;
			nmi_edge   <= next_nmi_edge;
			int_enable <= next_int_enable;
			clr_state  <= next_clr_state;
		end
	end

	// ==========================================================
	// apb read and answer
	logic [31:0] rdata_mux;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;

	always_comb
	begin
		case (paddr)
			`EID_OFF_SENSE_LOW:  rdata_mux = {26'h0000000, sense[5:0]};
			`EID_OFF_SENSE_HIGH: rdata_mux = {26'h0000000, sense[11:6]};
			`EID_OFF_STATUS:     rdata_mux = {26'h0000000, pending};
			`EID_OFF_ENABLE:     rdata_mux = {26'h0000000, enable};
			`EID_OFF_PRIO_A:     rdata_mux = {24'h000000, prio_a};
			`EID_OFF_PRIO_B:     rdata_mux = {24'h000000, prio_b};
			`EID_OFF_PRIO_INT:   rdata_mux = {24'h000000, prio_int};
			`EID_OFF_SYSCTL:     rdata_mux = {28'h0000000, nmi_edge, 3'h0};
			`EID_OFF_INT_FLAG:   rdata_mux = {28'h0000000, int_src_flag};
			`EID_OFF_INT_ENABLE: rdata_mux = {28'h0000000, int_enable};
			default:             rdata_mux = 32'h00000000;
		endcase
		next_pready  = psel & ~penable;
		next_prdata  = (psel & ~penable & ~pwrite) ? rdata_mux : prdata;
		next_pslverr = psel & ~penable & (paddr[1:0] != 2'h0 || paddr > `EID_OFF_INT_ENABLE);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			prdata  <= next_prdata;
			pready  <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ==========================================================
	// requests and arbitration
	logic       nmi_ev;
	logic       nmi_pend;
	logic [5:0] next_irq_req;
	logic [3:0] int_req;
	logic       next_nmi_pend;
	eid_req_t   next_best;
	logic       next_wake;
	logic [2:0] lvl;

	always_comb
	begin
		nmi_ev        = nmi_edge ? nmi_rise : nmi_fall;
		next_nmi_pend = (nmi_pend & ~nmi_taken) | nmi_ev;
		next_irq_req  = pending & enable;
		int_req       = int_src_flag & int_enable;
		next_best     = '0;
		lvl           = 3'h0;
		// strict greater keeps the lower source on equal levels
		for (int i = 0; i < `EID_NUM_IN; i++)
		begin
			lvl = (i < 2) ? prio_field(prio_a, i == 0) : prio_field(prio_b, i < 4);
			if (next_irq_req[i] && (!next_best.valid || lvl > next_best.level))
			begin
				next_best.valid  = 1'b1;
				next_best.level  = lvl;
				next_best.source = 4'(i);
			end
		end
		for (int j = 0; j < `EID_NUM_INT; j++)
		begin
			lvl = prio_field(prio_int, j < 2);
			if (int_req[j] && (!next_best.valid || lvl > next_best.level))
			begin
				next_best.valid  = 1'b1;
				next_best.level  = lvl;
				next_best.source = 4'(j + `EID_NUM_IN);
			end
		end
		next_wake = next_nmi_pend | (|next_irq_req);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			nmi_pend <= 1'b0;
			nmi_req  <= 1'b0;
			irq_req  <= 6'h00;
			best_req <= '0;
			wake_req <= 1'b0;
		end
		else
		begin
			nmi_pend <= next_nmi_pend;
			nmi_req  <= next_nmi_pend;
			irq_req  <= next_irq_req;
			best_req <= next_best;
			wake_req <= next_wake;
		end
	end

	// ==========================================================
	// checks
	AST_EDGE_SETS: assert property (@(posedge pclk) disable iff (!presetn)
		(sense[1:0] == 2'h1 && pin_fall[0]) |=> pending[0])
		else $error("falling edge did not set pending flag 0");
	AST_NO_BLIND_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == `EID_OFF_STATUS && !read_one[0] && pending[0]) |=> pending[0])
		else $error("pending flag cleared without prior read");
	AST_EXC_EDGE_CLR: assert property (@(posedge pclk) disable iff (!presetn)
		(sense[1:0] != 2'h0 && exc_taken[0] && !hit[0]) |=> !pending[0])
		else $error("edge mode exception did not clear flag 0");
	AST_EXC_LVL_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		(sense[3:2] == 2'h0 && !pin_lvl[1]) |=> pending[1])
		else $error("low level lost its pending flag");
	AST_ENABLE_GATE: assert property (@(posedge pclk) disable iff (!presetn)
		irq_req == ($past(pending) & $past(enable)))
		else $error("request not gated by enable");
	AST_NMI_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
		(nmi_edge && nmi_rise) |=> nmi_req)
		else $error("non-maskable rising edge not requested");
	AST_INT_GATE: assert property (@(posedge pclk) disable iff (!presetn)
		(best_req.valid && best_req.source >= 4'h6) |-> |($past(int_req) & (4'h1 << (best_req.source - 4'h6))))
		else $error("internal request without flag and enable");
	AST_PRIO_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
		(best_req.valid && best_req.source == 4'h0) |-> best_req.level == $past(prio_a[6:4]))
		else $error("input 0 carries wrong priority");
	AST_APB_ONE_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> pready)
		else $error("apb answer not in one cycle");

endmodule : eid_detect

// >>> rtl/eid_pkg.sv
// types shared by the external request detector
package eid_pkg;

	typedef enum logic [1:0]
	{
		EID_SENSE_LOW  = 2'h0,
		EID_SENSE_FALL = 2'h1,
		EID_SENSE_RISE = 2'h2,
		EID_SENSE_BOTH = 2'h3
	} eid_sense_t;

	typedef enum logic [1:0]
	{
		EID_CLR_IDLE  = 2'h0,
		EID_CLR_ARMED = 2'h1
	} eid_clr_state_t;

	typedef struct packed
	{
		logic       valid;
		logic [2:0] level;
		logic [3:0] source;
	} eid_req_t;

endpackage : eid_pkg

// >>> rtl/eid_sync.sv
// two-flip-flop synchroniser with edge outputs for request pins
`timescale 1ns/10ps
module eid_sync
	import eid_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin,
	output logic      level,
	output logic      fall,
	output logic      rise
);
	logic meta;
	logic sync;
	logic prev;

	// first stage feeds the second only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta <= 1'b1;
			sync <= 1'b1;
			prev <= 1'b1;
		end
		else
		begin
			meta <= pin;
			sync <= meta;
			prev <= sync;
		end
	end

	// edges compare consecutive synchronised samples
	assign level = sync;
	assign fall  = prev & ~sync;
	assign rise  = ~prev & sync;

endmodule : eid_sync
